// file: dmasf_pkg.sv
// Package: register map and field layout of the DMA status flag block
package dmasf_pkg;
   localparam int NUM_CH = 8;
   localparam logic [3:0] ADDR_COLLISION = 4'h0;
   localparam logic [3:0] ADDR_LAST_PP = 4'h1;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
   localparam int PERIPH_LSB = 8;
   localparam int BUFRAM_LSB = 0;
   localparam int LAST_CH_LSB = 8;
   localparam int PP_LSB = 0;
   localparam logic [3:0] LAST_CH_NONE = 4'hF;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] RDATA_ZERO = 16'h0000;
endpackage

// file: dmasf_status.sv
// DMA status logic: collision flags, last channel, ping-pong status
// Notes on behaviour
// - Peripheral-side collision flag of channel n is bit 8+n of status 0.
// - Buffer-RAM-side collision flag of channel n is bit n of status 0.
// - A flag reads 1 after a collision on its channel and side, 0 at reset.
// - Bits 11..8 of status 1 show the last channel, 1111 until a transfer.
// - Channels 0 to 7 show as their plain binary number, 0000 to 0111.
`timescale 1ns/1ps
module dmasf_status
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // Channel events, same clock domain
   input wire logic [7:0] periph_collision,
   input wire logic [7:0] bufram_collision,
   input wire logic [7:0] transfer_done,
   input wire logic [7:0] pingpong_secondary,
   // Interrupt
   output logic irq
);
   logic [7:0] periph_write_collision_flag;
   logic [7:0] buffer_ram_write_collision_flag;
   logic [3:0] last_active_channel;
   logic [7:0] pingpong_buffer_select_status;
   logic [15:0] irq_mask;
   logic [15:0] next_rdata;
   logic [3:0] next_last;
   logic clr_hit;

   assign clr_hit = wr && (addr == dmasf_pkg::ADDR_COLLISION);

   // Set wins over a write-one clear in the same cycle
   genvar g;
   generate
      for (g = 0; g < dmasf_pkg::NUM_CH; g++)
      begin : g_flag
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
            begin
               periph_write_collision_flag[g] <= 1'b0;
               buffer_ram_write_collision_flag[g] <= 1'b0;
            end
            else
            begin
               if (periph_collision[g])
                  periph_write_collision_flag[g] <= 1'b1;
               else if (clr_hit && wdata[dmasf_pkg::PERIPH_LSB + g])
                  periph_write_collision_flag[g] <= 1'b0;
               if (bufram_collision[g])
                  buffer_ram_write_collision_flag[g] <= 1'b1;
               else if (clr_hit && wdata[dmasf_pkg::BUFRAM_LSB + g])
                  buffer_ram_write_collision_flag[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Set beats clear, so a collision is never lost to a late clear
   chk_periph_set_wins: assert property (
      @(posedge clk_sys) disable iff (rst)
      periph_collision[0] && clr_hit && wdata[dmasf_pkg::PERIPH_LSB]
      |=> periph_write_collision_flag[0])
      else $error("peripheral flag set lost against clear");
   chk_bufram_set_wins: assert property (
      @(posedge clk_sys) disable iff (rst)
      bufram_collision[0] && clr_hit && wdata[dmasf_pkg::BUFRAM_LSB]
      |=> buffer_ram_write_collision_flag[0])
      else $error("buffer RAM flag set lost against clear");
   chk_periph_clear: assert property (
      @(posedge clk_sys) disable iff (rst)
      clr_hit && wdata[dmasf_pkg::PERIPH_LSB + 7] && !periph_collision[7]
      |=> !periph_write_collision_flag[7])
      else $error("peripheral collision flag not cleared");
   chk_bufram_sticky: assert property (
      @(posedge clk_sys) disable iff (rst)
      buffer_ram_write_collision_flag[7] && !clr_hit
      |=> buffer_ram_write_collision_flag[7])
      else $error("buffer RAM flag dropped without clear");

   // Lowest channel wins if several finish together; the engine
   // serialises transfers, so this is only a tie-break
   always_comb
   begin
      next_last = last_active_channel;
      for (int i = dmasf_pkg::NUM_CH - 1; i >= 0; i--)
         if (transfer_done[i])
            next_last = 4'(i);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         last_active_channel <= dmasf_pkg::LAST_CH_NONE;
      else
         last_active_channel <= next_last;
   end

   chk_last_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      transfer_done == 8'h00 |=> $stable(last_active_channel))
      else $error("last channel changed without transfer");
   chk_last_chan0: assert property (
      @(posedge clk_sys) disable iff (rst)
      transfer_done[0] |=> last_active_channel == 4'h0)
      else $error("channel 0 not recorded");

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         pingpong_buffer_select_status <= dmasf_pkg::FLAGS_RESET;
      else
         pingpong_buffer_select_status <= pingpong_secondary;
   end

   chk_pingpong_follow: assert property (
      @(posedge clk_sys) disable iff (rst)
      1'b1 |=> pingpong_buffer_select_status == $past(pingpong_secondary))
      else $error("ping-pong status does not follow channel");

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         irq_mask <= dmasf_pkg::MASK_RESET;
      else if (wr && addr == dmasf_pkg::ADDR_IRQ_MASK)
         irq_mask <= wdata;
   end

   chk_mask_write: assert property (@(posedge clk_sys) disable iff (rst)
      wr && addr == dmasf_pkg::ADDR_IRQ_MASK |=> irq_mask == $past(wdata))
      else $error("interrupt mask write lost");

   always_comb
   begin
      next_rdata = dmasf_pkg::RDATA_ZERO;
      case (addr)
         dmasf_pkg::ADDR_COLLISION:
            next_rdata = {periph_write_collision_flag,
                          buffer_ram_write_collision_flag};
         dmasf_pkg::ADDR_LAST_PP:
            next_rdata = {4'h0, last_active_channel,
                          pingpong_buffer_select_status};
         dmasf_pkg::ADDR_IRQ_MASK:
            next_rdata = irq_mask;
         default:
            next_rdata = dmasf_pkg::RDATA_ZERO;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rdata <= dmasf_pkg::RDATA_ZERO;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= dmasf_pkg::RDATA_ZERO;
   end

   // Idle zero lets software OR several read ports together
   chk_collision_read: assert property (
      @(posedge clk_sys) disable iff (rst)
      rd && addr == dmasf_pkg::ADDR_COLLISION |=> rdata == $past(
      {periph_write_collision_flag, buffer_ram_write_collision_flag}))
      else $error("collision status read mismatch");
   chk_last_read: assert property (
      @(posedge clk_sys) disable iff (rst)
      rd && addr == dmasf_pkg::ADDR_LAST_PP
      |=> rdata[15:8] == {4'h0, $past(last_active_channel)})
      else $error("last channel read mismatch");
   chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
      !rd |=> rdata == dmasf_pkg::RDATA_ZERO)
      else $error("read data outside read cycle");
   chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (rst)
      rd && addr > dmasf_pkg::ADDR_IRQ_MASK
      |=> rdata == dmasf_pkg::RDATA_ZERO)
      else $error("unmapped read not zero");

   // Registered, so irq lags the flag by one cycle
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |({periph_write_collision_flag,
                   buffer_ram_write_collision_flag} & irq_mask);
   end

   chk_irq_follow: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> irq == $past(|({periph_write_collision_flag,
                               buffer_ram_write_collision_flag} & irq_mask)))
      else $error("interrupt does not follow unmasked flags");

   chk_periph_flag_set: assert property (
      @(posedge clk_sys) disable iff (rst)
      periph_collision[3] |=> periph_write_collision_flag[3])
      else $error("peripheral collision flag not set");
   chk_bufram_flag_set: assert property (
      @(posedge clk_sys) disable iff (rst)
      bufram_collision[5] |=> buffer_ram_write_collision_flag[5])
      else $error("buffer RAM collision flag not set");
   chk_flag_sticky: assert property (
      @(posedge clk_sys) disable iff (rst)
      periph_write_collision_flag[0] && !clr_hit
      |=> periph_write_collision_flag[0])
      else $error("collision flag dropped without clear");
   chk_flag_clear: assert property (
      @(posedge clk_sys) disable iff (rst)
      clr_hit && wdata[0] && !bufram_collision[0]
      |=> !buffer_ram_write_collision_flag[0])
      else $error("collision flag not cleared");
   chk_last_none: assert property (
      @(posedge clk_sys) disable iff (rst)
      last_active_channel != dmasf_pkg::LAST_CH_NONE
      |=> last_active_channel != dmasf_pkg::LAST_CH_NONE)
      else $error("last channel returned to none");
   chk_last_valid: assert property (
      @(posedge clk_sys) disable iff (rst)
      last_active_channel == dmasf_pkg::LAST_CH_NONE
      || last_active_channel < 4'h8)
      else $error("last channel holds reserved code");
   chk_last_code: assert property (
      @(posedge clk_sys) disable iff (rst)
      transfer_done[6] && transfer_done[5:0] == 6'h00
      |=> last_active_channel == 4'h6)
      else $error("last channel code wrong");
   chk_pingpong_read: assert property (
      @(posedge clk_sys) disable iff (rst)
      rd && addr == dmasf_pkg::ADDR_LAST_PP
      |=> rdata[7:0] == $past(pingpong_buffer_select_status))
      else $error("ping-pong read mismatch");
endmodule

// file: test_dma_status_collision_flags.sv
// Self-checking testbench of the DMA status flag block
`timescale 1ns/1ps
module test_dma_status_collision_flags;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] pc = 8'h00, bc = 8'h00, td = 8'h00, pp = 8'h00;
   logic [15:0] rdata;
   logic irq;
   logic [15:0] ef, m, d;
   int error_cnt = 0;
   int n_checks = 0;
   dmasf_status i_dmasf_status (.clk_sys(clk_sys), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .periph_collision(pc), .bufram_collision(bc), .transfer_done(td),
      .pingpong_secondary(pp), .irq(irq));
   always #12.5 clk_sys = ~clk_sys;
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] irq_exp(input logic [15:0] f,
                                           input logic [15:0] k);
      irq_exp = {15'h0, |(f & k)};
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task wreg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task rreg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task ev(input logic [7:0] p, b, t, s);
      @(posedge clk_sys);
      pc <= p;
      bc <= b;
      td <= t;
      pp <= s;
      ef = ef | {p, b};
      @(posedge clk_sys);
      pc <= 8'h00;
      bc <= 8'h00;
      td <= 8'h00;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      error_cnt++;
      end_of_test;
   end
   initial
   begin
      void'($urandom(32'h6e3a543a));
      ef = 16'h0000;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rreg(dmasf_pkg::ADDR_COLLISION, 16'h0000);
      rreg(dmasf_pkg::ADDR_LAST_PP, 16'h0F00);
      rreg(4'hC, 16'h0000);
      rreg(dmasf_pkg::ADDR_IRQ_MASK, 16'h0000);
      $display("test reset done");
      m = 16'($urandom);
      wreg(dmasf_pkg::ADDR_IRQ_MASK, m);
      rreg(dmasf_pkg::ADDR_IRQ_MASK, m);
      for (int i = 0; i < 20; i++)
      begin
         ev(8'($urandom), 8'($urandom), 8'h00, pp);
         rreg(dmasf_pkg::ADDR_COLLISION, ef);
         check({15'h0, irq}, irq_exp(ef, m));
         d = 16'($urandom);
         wreg(dmasf_pkg::ADDR_COLLISION, d);
         ef = ef & ~d;
      end
      // Corner: event and write-one clear in one cycle, set must win
      @(posedge clk_sys);
      pc <= 8'h01;
      bc <= 8'h01;
      addr <= dmasf_pkg::ADDR_COLLISION;
      wdata <= 16'h0101;
      wr <= 1'b1;
      @(posedge clk_sys);
      pc <= 8'h00;
      bc <= 8'h00;
      wr <= 1'b0;
      ef = ef | 16'h0101;
      rreg(dmasf_pkg::ADDR_COLLISION, ef);
      check({15'h0, irq}, irq_exp(ef, m));
      wreg(dmasf_pkg::ADDR_COLLISION, 16'hFFFF);
      ef = 16'h0000;
      rreg(dmasf_pkg::ADDR_COLLISION, 16'h0000);
      check({15'h0, irq}, irq_exp(ef, m));
      $display("test collision flags done");
      // Extra higher channels in the pulse: lowest must win
      for (int n = 0; n < 8; n++)
      begin
         ev(8'h00, 8'h00, 8'(8'h01 << n) | 8'($urandom << (n + 1)),
            8'($urandom));
         rreg(dmasf_pkg::ADDR_LAST_PP, {4'h0, 4'(n), pp});
         wreg(dmasf_pkg::ADDR_LAST_PP, 16'hFFFF);
         rreg(dmasf_pkg::ADDR_LAST_PP, {4'h0, 4'(n), pp});
      end
      $display("test last channel done");
      end_of_test;
   end
endmodule
